/* File: hw/configurable_serial_port.sv */
// holds the configurable serial port: transmitter, receiver, timeout and register file
// assumes all pin inputs synchronous to clock and a single-cycle strobe register port
//
// Strobed register access and the placing of the registers were decided locally.
module configurable_serial_port #(
   parameter int unsigned ms_cycles = serial_port_pkg::MS_CYCLES
) (
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // register port
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   // serial pins
   input wire logic tx_in,
   output logic tx_out,
   output logic tx_oe,
   input wire logic rx_in,
   input wire logic return_in,
   output logic enable_out,
   // system side
   output logic irq,
   output logic int_block,
   output logic wdt_clear
);

   serial_port_pkg::cfg_t cfg, next_cfg;
   logic [15:0] div, next_div, tmo, next_tmo;
   logic [7:0] serial_error_flags, next_flags;
   logic [3:0] irq_stat, next_stat, irq_mask, next_mask;
   logic [31:0] next_rdata;
   logic next_irq, next_int_block, next_enable;
   serial_port_pkg::tx_state_t ts, next_ts;
   logic [15:0] tcnt, next_tcnt;
   logic [3:0] tbit, next_tbit;
   logic [8:0] tsh, next_tsh;
   logic tpar, next_tpar, next_tx_out, next_tx_oe;
   logic tlevel, t_end, tx_req, tx_done, tx_err, rb, line, drive, shared;
   serial_port_pkg::rx_state_t rs, next_rs;
   logic [15:0] rcnt, next_rcnt, rx_data, next_rx_data, mleft, next_mleft;
   logic [3:0] rbit, next_rbit;
   logic [8:0] rsh, next_rsh;
   logic [31:0] mcnt, next_mcnt;
   logic rpar, next_rpar, rline_d, sclk_d, rx_valid, next_rx_valid;
   logic waiting, next_waiting, next_wdt;
   logic rline, r_end, r_samp, s_rise, s_fall, rd_rx, got;
   logic rx_done, par_evt, frm_evt, ovr_evt, tmo_evt;
   logic [3:0] len;
   logic [8:0] lmask;

   // effective word length and data mask
   always_comb begin
      if (cfg.wide_word) begin
         len = serial_port_pkg::WIDE_LEN;
      end else if (cfg.word_len >= serial_port_pkg::MIN_LEN &&
                   cfg.word_len <= serial_port_pkg::DEF_LEN) begin
         len = cfg.word_len;
      end else begin
         len = serial_port_pkg::DEF_LEN;
      end
      // shift in 18 bits so the ones above bit 8 survive before the right shift
      lmask = 9'((18'h0_01FF << len) >> serial_port_pkg::WIDE_LEN);
   end

   // readback source and received line level
   always_comb begin
      shared = cfg.debug_probe_stream | cfg.sync_follower;
      if (cfg.use_return) begin
         rb = return_in ^ cfg.invert;
      end else begin
         rb = (cfg.open_drain ? tx_in : rx_in) ^ cfg.invert;
      end
      rline = (shared ? tx_in : rx_in) ^ cfg.invert;
      s_rise = rx_in & ~sclk_d;
      s_fall = ~rx_in & sclk_d;
   end

   // transmitter next state
   always_comb begin
      next_ts = ts;
      next_tcnt = tcnt;
      next_tbit = tbit;
      next_tsh = tsh;
      next_tpar = tpar;
      tx_done = 1'b0;
      tx_err = 1'b0;
      case (ts)
         serial_port_pkg::TX_START: tlevel = 1'b0;
         serial_port_pkg::TX_DATA: tlevel = tsh[0];
         serial_port_pkg::TX_PARITY: tlevel = tpar;
         default: tlevel = 1'b1;
      endcase
      t_end = tcnt == div - 16'h0001;
      tx_req = wr && addr == serial_port_pkg::ADDR_TXDATA && ts == serial_port_pkg::TX_IDLE &&
               !(cfg.multi_master && serial_error_flags[serial_port_pkg::ERR_LINE]);
      if (ts != serial_port_pkg::TX_IDLE && !cfg.sync_follower) begin
         next_tcnt = t_end ? 16'h0000 : tcnt + 16'h0001;
      end
      case (ts)
         serial_port_pkg::TX_IDLE: begin
            if (tx_req) begin
               next_tsh = wdata[8:0] & lmask;
               next_tpar = (^(wdata[8:0] & lmask)) ^ (cfg.parity == serial_port_pkg::PAR_ODD);
               next_tcnt = 16'h0000;
               next_tbit = 4'h0;
               next_ts = cfg.sync_follower ? serial_port_pkg::TX_DATA : serial_port_pkg::TX_START;
            end
         end
         serial_port_pkg::TX_START: begin
            if (t_end) begin
               next_ts = serial_port_pkg::TX_DATA;
            end
         end
         serial_port_pkg::TX_DATA: begin
            // follower mode shifts on the remote clock's falling edge
            if (cfg.sync_follower ? s_fall : t_end) begin
               next_tsh = tsh >> 1;
               next_tbit = tbit + 4'h1;
               if (tbit == len - 4'h1) begin
                  next_tbit = 4'h0;
                  if (cfg.sync_follower) begin
                     next_ts = serial_port_pkg::TX_IDLE;
                     tx_done = 1'b1;
                  end else if (cfg.parity != serial_port_pkg::PAR_NONE) begin
                     next_ts = serial_port_pkg::TX_PARITY;
                  end else begin
                     next_ts = serial_port_pkg::TX_STOP;
                  end
               end
            end
         end
         serial_port_pkg::TX_PARITY: begin
            if (t_end) begin
               next_ts = serial_port_pkg::TX_STOP;
            end
         end
         serial_port_pkg::TX_STOP: begin
            if (t_end) begin
               if (tbit == {3'h0, cfg.two_stop}) begin
                  next_ts = serial_port_pkg::TX_IDLE;
                  tx_done = 1'b1;
               end else begin
                  next_tbit = tbit + 4'h1;
               end
            end
         end
         default: next_ts = serial_port_pkg::TX_IDLE;
      endcase
      // collision check at bit start and end, released-line check at bit end
      if (ts != serial_port_pkg::TX_IDLE && !cfg.sync_follower) begin
         if (cfg.multi_master && (tcnt == serial_port_pkg::CHECK_OFS || t_end) &&
             rb != tlevel) begin
            tx_err = 1'b1;
            next_ts = serial_port_pkg::TX_IDLE;
         end else if (cfg.open_drain && t_end && tlevel && !rb) begin
            tx_err = 1'b1;
         end
      end
      // pin drive: open drain only pulls low, shared pin released when idle
      line = tlevel ^ cfg.invert;
      if (cfg.open_drain) begin
         drive = !line && (ts != serial_port_pkg::TX_IDLE || !shared);
      end else begin
         drive = ts != serial_port_pkg::TX_IDLE || !shared;
      end
      next_tx_out = line & ~cfg.open_drain;
      next_tx_oe = ~drive;
   end

   // transmitter registers
   always_ff @(posedge clock) begin
      if (!nrst) begin
         ts <= serial_port_pkg::TX_IDLE;
         tcnt <= 16'h0000;
         tbit <= 4'h0;
         tsh <= 9'h000;
         tpar <= 1'b0;
         tx_out <= 1'b1;
         tx_oe <= 1'b1;
      end else begin
         ts <= next_ts;
         tcnt <= next_tcnt;
         tbit <= next_tbit;
         tsh <= next_tsh;
         tpar <= next_tpar;
         tx_out <= next_tx_out;
         tx_oe <= next_tx_oe;
      end
   end

   // receiver and receive timeout next state
   always_comb begin
      next_rs = rs;
      next_rcnt = rcnt;
      next_rbit = rbit;
      next_rsh = rsh;
      next_rpar = rpar;
      next_rx_data = rx_data;
      next_rx_valid = rx_valid;
      next_waiting = waiting;
      next_mcnt = mcnt;
      next_mleft = mleft;
      got = 1'b0;
      rx_done = 1'b0;
      par_evt = 1'b0;
      frm_evt = 1'b0;
      ovr_evt = 1'b0;
      tmo_evt = 1'b0;
      rd_rx = rd && addr == serial_port_pkg::ADDR_RXDATA;
      r_end = rcnt == div - 16'h0001;
      r_samp = cfg.early_sample ? rcnt == 16'h0000 : rcnt == (div >> 1);
      if (rd_rx) begin
         next_rx_valid = 1'b0;
      end
      if (rs != serial_port_pkg::RX_IDLE) begin
         next_rcnt = r_end ? 16'h0000 : rcnt + 16'h0001;
      end
      case (rs)
         serial_port_pkg::RX_IDLE: begin
            if (cfg.sync_follower) begin
               if (s_rise && ts == serial_port_pkg::TX_IDLE) begin
                  next_rsh = {rline, rsh[8:1]};
                  next_rbit = rbit + 4'h1;
                  if (rbit == len - 4'h1) begin
                     next_rbit = 4'h0;
                     got = 1'b1;
                  end
               end
            end else if (rline_d && !rline &&
                         !(cfg.debug_probe_stream && ts != serial_port_pkg::TX_IDLE)) begin
               next_rs = serial_port_pkg::RX_START;
               next_rcnt = 16'h0000;
               next_rbit = 4'h0;
               next_rpar = 1'b0;
            end
         end
         serial_port_pkg::RX_START: begin
            if (r_samp && rline) begin
               next_rs = serial_port_pkg::RX_IDLE; // false start
            end else if (r_end) begin
               next_rs = serial_port_pkg::RX_DATA;
            end
         end
         serial_port_pkg::RX_DATA: begin
            if (r_samp) begin
               next_rsh = {rline, rsh[8:1]};
               next_rpar = rpar ^ rline;
            end
            if (r_end) begin
               next_rbit = rbit + 4'h1;
               if (rbit == len - 4'h1) begin
                  next_rbit = 4'h0;
                  next_rs = (cfg.parity != serial_port_pkg::PAR_NONE) ?
                            serial_port_pkg::RX_PARITY : serial_port_pkg::RX_STOP;
               end
            end
         end
         serial_port_pkg::RX_PARITY: begin
            if (r_samp && ((rpar ^ rline) != (cfg.parity == serial_port_pkg::PAR_ODD))) begin
               par_evt = 1'b1;
            end
            if (r_end) begin
               next_rs = serial_port_pkg::RX_STOP;
            end
         end
         serial_port_pkg::RX_STOP: begin
            if (r_samp) begin
               got = 1'b1;
               frm_evt = !rline;
               next_rs = serial_port_pkg::RX_IDLE; // receiver recovers after an error
            end
         end
         default: next_rs = serial_port_pkg::RX_IDLE;
      endcase
      if (got) begin
         next_rx_data = {7'h00, next_rsh >> (serial_port_pkg::WIDE_LEN - len)};
         ovr_evt = rx_valid && !rd_rx;
         next_rx_valid = 1'b1;
         rx_done = 1'b1;
         next_waiting = 1'b0;
      end
      // request timeout counted in whole milliseconds, zero waits forever
      if (wr && addr == serial_port_pkg::ADDR_RXREQ) begin
         next_waiting = 1'b1;
         next_mcnt = 32'h0000_0000;
         next_mleft = tmo;
      end else if (waiting && !got) begin
         if (mcnt == 32'(ms_cycles - 1)) begin
            next_mcnt = 32'h0000_0000;
            if (mleft != 16'h0000) begin
               next_mleft = mleft - 16'h0001;
               if (mleft == 16'h0001) begin
                  tmo_evt = 1'b1;
                  next_waiting = 1'b0;
                  next_rx_data = 16'h0000;
               end
            end
         end else begin
            next_mcnt = mcnt + 32'h0000_0001;
         end
      end
      next_wdt = cfg.watchdog_service_option && waiting && mcnt == 32'h0000_0000;
   end

   // receiver registers
   always_ff @(posedge clock) begin
      if (!nrst) begin
         rs <= serial_port_pkg::RX_IDLE;
         rcnt <= 16'h0000;
         rbit <= 4'h0;
         rsh <= 9'h000;
         rpar <= 1'b0;
         rline_d <= 1'b1;
         sclk_d <= 1'b0;
         rx_data <= 16'h0000;
         rx_valid <= 1'b0;
         waiting <= 1'b0;
         mcnt <= 32'h0000_0000;
         mleft <= 16'h0000;
         wdt_clear <= 1'b0;
      end else begin
         rs <= next_rs;
         rcnt <= next_rcnt;
         rbit <= next_rbit;
         rsh <= next_rsh;
         rpar <= next_rpar;
         rline_d <= rline;
         sclk_d <= rx_in;
         rx_data <= next_rx_data;
         rx_valid <= next_rx_valid;
         waiting <= next_waiting;
         mcnt <= next_mcnt;
         mleft <= next_mleft;
         wdt_clear <= next_wdt;
      end
   end

   // register file, error flags, interrupts and read data
   always_comb begin
      next_cfg = cfg;
      next_div = div;
      next_tmo = tmo;
      next_flags = serial_error_flags;
      next_stat = irq_stat;
      next_mask = irq_mask;
      next_rdata = 32'h0000_0000;
      if (wr) begin
         case (addr)
            serial_port_pkg::ADDR_CTRL: next_cfg = wdata[serial_port_pkg::CFG_W-1:0];
            serial_port_pkg::ADDR_DIV: next_div = wdata[15:0];
            serial_port_pkg::ADDR_TIMEOUT: next_tmo = wdata[15:0];
            serial_port_pkg::ADDR_ERRORS: next_flags = serial_error_flags & ~wdata[7:0];
            serial_port_pkg::ADDR_IRQ_STAT: next_stat = irq_stat & ~wdata[3:0];
            serial_port_pkg::ADDR_IRQ_MASK: next_mask = wdata[3:0];
            default: ;
         endcase
      end
      if (tmo_evt) begin
         next_flags = 8'h00;
      end
      // sets come after clears so a same-cycle event is kept
      if (cfg.errors_enable) begin
         next_flags[serial_port_pkg::ERR_PARITY] = next_flags[serial_port_pkg::ERR_PARITY] | par_evt;
         next_flags[serial_port_pkg::ERR_FRAMING] =
            next_flags[serial_port_pkg::ERR_FRAMING] | frm_evt;
         next_flags[serial_port_pkg::ERR_OVERRUN] =
            next_flags[serial_port_pkg::ERR_OVERRUN] | ovr_evt;
      end
      next_flags[serial_port_pkg::ERR_LINE] = next_flags[serial_port_pkg::ERR_LINE] | tx_err;
      next_stat[serial_port_pkg::IRQ_TX_DONE] = next_stat[serial_port_pkg::IRQ_TX_DONE] | tx_done;
      next_stat[serial_port_pkg::IRQ_RX_DONE] = next_stat[serial_port_pkg::IRQ_RX_DONE] | rx_done;
      next_stat[serial_port_pkg::IRQ_TIMEOUT] = next_stat[serial_port_pkg::IRQ_TIMEOUT] | tmo_evt;
      next_stat[serial_port_pkg::IRQ_ERROR] = next_stat[serial_port_pkg::IRQ_ERROR] | tx_err |
                                              (cfg.errors_enable & (par_evt | frm_evt | ovr_evt));
      if (rd) begin
         case (addr)
            serial_port_pkg::ADDR_CTRL: next_rdata = {13'h0, cfg};
            serial_port_pkg::ADDR_DIV: next_rdata = {16'h0, div};
            serial_port_pkg::ADDR_TIMEOUT: next_rdata = {16'h0, tmo};
            serial_port_pkg::ADDR_RXDATA: next_rdata = {16'h0, rx_data};
            serial_port_pkg::ADDR_ERRORS: next_rdata = {24'h0, serial_error_flags};
            serial_port_pkg::ADDR_STATUS:
               next_rdata = {29'h0, waiting, rx_valid, ts != serial_port_pkg::TX_IDLE};
            serial_port_pkg::ADDR_IRQ_STAT: next_rdata = {28'h0, irq_stat};
            serial_port_pkg::ADDR_IRQ_MASK: next_rdata = {28'h0, irq_mask};
            default: next_rdata = 32'h0000_0000;
         endcase
      end
      next_irq = |(next_stat & next_mask);
      // follow the current state so enable lines up with the registered pin level
      next_enable = cfg.driver_enable && ts != serial_port_pkg::TX_IDLE;
      next_int_block = cfg.interrupt_mask_option && (ts != serial_port_pkg::TX_IDLE ||
                       rs != serial_port_pkg::RX_IDLE);
   end

   // register file registers
   always_ff @(posedge clock) begin
      if (!nrst) begin
         cfg <= serial_port_pkg::CTRL_RESET;
         div <= serial_port_pkg::DIV_RESET;
         tmo <= serial_port_pkg::TIMEOUT_RESET;
         serial_error_flags <= 8'h00;
         irq_stat <= 4'h0;
         irq_mask <= 4'h0;
         rdata <= 32'h0000_0000;
         irq <= 1'b0;
         enable_out <= 1'b0;
         int_block <= 1'b0;
      end else begin
         cfg <= next_cfg;
         div <= next_div;
         tmo <= next_tmo;
         serial_error_flags <= next_flags;
         irq_stat <= next_stat;
         irq_mask <= next_mask;
         rdata <= next_rdata;
         irq <= next_irq;
         enable_out <= next_enable;
         int_block <= next_int_block;
      end
   end

   // checks on the design's own outputs and internal state
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);

   AST_DE_DURING_TX: assert property (
      (ts != serial_port_pkg::TX_IDLE && cfg.driver_enable && $stable(cfg)) |=> enable_out)
      else $error("enable pin low during transmission");
   AST_OD_NEVER_HIGH: assert property (
      (cfg.open_drain && $stable(cfg) && !tx_oe) |-> !tx_out)
      else $error("open drain line driven high");
   AST_START_LEVEL: assert property (
      (ts == serial_port_pkg::TX_START && !cfg.sync_follower && $stable(cfg))
      |=> tx_out == (cfg.invert & ~cfg.open_drain))
      else $error("start bit not at low level");
   AST_COLLISION_ABORT: assert property (
      (tx_err && cfg.multi_master) |=> (ts == serial_port_pkg::TX_IDLE &&
      serial_error_flags[serial_port_pkg::ERR_LINE]))
      else $error("collision did not abort and flag");
   AST_LINE_ERR_BLOCKS: assert property (
      (cfg.multi_master && serial_error_flags[serial_port_pkg::ERR_LINE] &&
      ts == serial_port_pkg::TX_IDLE) |=> ts == serial_port_pkg::TX_IDLE)
      else $error("transmit started while collision flag set");
   AST_TIMEOUT_ZERO: assert property (
      (tmo_evt && !tx_err && !par_evt && !frm_evt) |=>
      (rx_data == 16'h0000 && serial_error_flags == 8'h00 && !waiting))
      else $error("timeout did not zero data and flags");
   AST_PARITY_RECORD: assert property (
      (par_evt && cfg.errors_enable) |=> serial_error_flags[serial_port_pkg::ERR_PARITY] ##1
      (serial_error_flags[serial_port_pkg::ERR_PARITY] || $past(wr)))
      else $error("parity error not recorded");
   AST_INT_BLOCK: assert property (
      (cfg.interrupt_mask_option && $stable(cfg) && ts != serial_port_pkg::TX_IDLE) |=> int_block)
      else $error("interrupts not blocked during transmit");
   AST_WDT_WAITING: assert property (
      wdt_clear |-> ($past(waiting) && $past(cfg.watchdog_service_option)))
      else $error("watchdog cleared while not waiting");

endmodule // configurable_serial_port

/* File: hw/serial_port_pkg.sv */
// holds register offsets, field layouts, encodings and timing counts of the serial port
// assumes a 100 MHz system clock and an 8-bit register address port
package serial_port_pkg;

   // register offsets, one 32-bit word each
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_DIV = 8'h04;
   localparam logic [7:0] ADDR_TXDATA = 8'h08;
   localparam logic [7:0] ADDR_RXDATA = 8'h0C;
   localparam logic [7:0] ADDR_RXREQ = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   localparam logic [7:0] ADDR_ERRORS = 8'h18;
   localparam logic [7:0] ADDR_TIMEOUT = 8'h1C;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h20;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h24;

   // parity setting
   typedef enum logic [1:0] {
      PAR_NONE = 2'b00,
      PAR_EVEN = 2'b01,
      PAR_ODD = 2'b10
   } parity_t;

   // control register layout, msb first
   typedef struct packed {
      logic debug_probe_stream;
      logic sync_follower;
      logic watchdog_service_option;
      logic interrupt_mask_option;
      logic wide_word;
      logic errors_enable;
      logic early_sample;
      logic use_return;
      logic multi_master;
      logic open_drain;
      logic invert;
      logic two_stop;
      logic driver_enable;
      parity_t parity;
      logic [3:0] word_len;
   } cfg_t;

   localparam int CFG_W = 19;
   localparam cfg_t CTRL_RESET = 19'h0_0008;
   localparam logic [15:0] DIV_RESET = 16'h0364;
   localparam logic [15:0] TIMEOUT_RESET = 16'h0000;

   // word length limits
   localparam logic [3:0] MIN_LEN = 4'h5;
   localparam logic [3:0] DEF_LEN = 4'h8;
   localparam logic [3:0] WIDE_LEN = 4'h9;

   // error flag and interrupt bit positions
   localparam int ERR_PARITY = 0;
   localparam int ERR_FRAMING = 1;
   localparam int ERR_OVERRUN = 2;
   localparam int ERR_LINE = 6;
   localparam int IRQ_TX_DONE = 0;
   localparam int IRQ_RX_DONE = 1;
   localparam int IRQ_TIMEOUT = 2;
   localparam int IRQ_ERROR = 3;

   // start-of-bit readback offset in cycles, and timing
   localparam logic [15:0] CHECK_OFS = 16'h0001;
   localparam int unsigned CLOCK_PERIOD_NS = 10;
   localparam int unsigned MS_NS = 1000000;
   localparam int unsigned MS_CYCLES = MS_NS / CLOCK_PERIOD_NS;

   // transmit and receive states
   typedef enum logic [2:0] {
      TX_IDLE = 3'b000,
      TX_START = 3'b001,
      TX_DATA = 3'b010,
      TX_PARITY = 3'b011,
      TX_STOP = 3'b100
   } tx_state_t;

   typedef enum logic [2:0] {
      RX_IDLE = 3'b000,
      RX_START = 3'b001,
      RX_DATA = 3'b010,
      RX_PARITY = 3'b011,
      RX_STOP = 3'b100
   } rx_state_t;

endpackage

/* File: test/serial_line_model.sv */
// remote transceiver on the far side of the serial pins
// assumes a pulled-up shared transmit line and a pulled-up receive line
module serial_line_model (
   // system clock
   input wire logic clock,
   // device pins
   input wire logic tx_out,
   input wire logic tx_oe,
   input wire logic jam,
   output logic tx_line,
   output logic return_line,
   output logic rx_line
);
   timeunit 1ns;
   timeprecision 1ns;
   // pull-up wins whenever the device releases the pin
   assign tx_line = tx_oe ? 1'b1 : tx_out;
   // a colliding master holds the readback low
   assign return_line = jam ? 1'b0 : tx_line;
   initial rx_line = 1'b1;
   // one frame: low start, lsb first, optional parity, one high stop
   task automatic send(input logic [8:0] d, input int n, input bit par, input logic pb,
      input int div);
      @(posedge clock);
      rx_line <= 1'b0;
      repeat (div) @(posedge clock);
      for (int i = 0; i < n; i++) begin
         rx_line <= d[i];
         repeat (div) @(posedge clock);
      end
      if (par) begin
         rx_line <= pb;
         repeat (div) @(posedge clock);
      end
      rx_line <= 1'b1;
      repeat (div) @(posedge clock);
   endtask
endmodule // serial_line_model

/* File: test/configurable_serial_port_tb.sv */
// self-checking bench of the serial port against a remote line model
// assumes a shortened millisecond count and a bit period of four clocks
module configurable_serial_port_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock, nrst, wr, rd, jam, tx_out, tx_oe, tx_line, rx_line, return_line;
   logic enable_out, irq, int_block, wdt_clear;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, v;
   int mismatches = 0;
   int cmp_count = 0;
   // design and remote line
   configurable_serial_port #(.ms_cycles(20)) dut_u (.clock(clock), .nrst(nrst), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .tx_in(tx_line), .tx_out(tx_out),
      .tx_oe(tx_oe), .rx_in(rx_line), .return_in(return_line), .enable_out(enable_out),
      .irq(irq), .int_block(int_block), .wdt_clear(wdt_clear));
   serial_line_model line_u (.clock(clock), .tx_out(tx_out), .tx_oe(tx_oe), .jam(jam),
      .tx_line(tx_line), .return_line(return_line), .rx_line(rx_line));
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wrap_up;
      if (mismatches == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic wait_idle;
      for (int i = 0; i < 200; i++) begin
         rd_reg(serial_port_pkg::ADDR_STATUS, v);
         if (v[0] === 1'b0)
            return;
      end
      chk("idle wait", 0, 1);
      wrap_up;
   endtask
   // send one word and sample the pin in the last clock of every bit
   task automatic tx_frame(input logic [1:0] p, input logic st, input logic [7:0] d);
      logic [11:0] f;
      f = (p != 2'b00) ? {2'b11, (p == 2'b10) ^ (^d), d, 1'b0} : {3'b111, d, 1'b0};
      wr_reg(serial_port_pkg::ADDR_CTRL, 32'h0000_8048 | {p, 4'h0} | {st, 7'h00});
      wr_reg(serial_port_pkg::ADDR_TXDATA, {24'h0, d});
      repeat (4) @(posedge clock);
      for (int i = 0; i < 10 + (p != 0) + st; i++) begin
         #1 chk("tx bit", f[i], tx_line);
         chk("enable and block", 2'b11, {enable_out, int_block});
         repeat (4) @(posedge clock);
      end
      wait_idle;
   endtask
   // a good odd-parity word, then a corrupted one
   task automatic rx_parity;
      #1 chk("irq masked", 0, irq);
      wr_reg(serial_port_pkg::ADDR_CTRL, 32'h0000_2028);
      wr_reg(serial_port_pkg::ADDR_IRQ_STAT, 32'h0000_000F);
      wr_reg(serial_port_pkg::ADDR_IRQ_MASK, 32'h0000_0002);
      line_u.send(9'h03C, 8, 1'b1, 1'b1, 4);
      repeat (3) @(posedge clock);
      #1 chk("irq", 1, irq);
      rd_reg(serial_port_pkg::ADDR_RXDATA, v);
      chk("rx data", 32'h0000_003C, v);
      wr_reg(serial_port_pkg::ADDR_IRQ_STAT, 32'h0000_0002);
      repeat (2) @(posedge clock);
      #1 chk("irq cleared", 0, irq);
      line_u.send(9'h03C, 8, 1'b1, 1'b0, 4);
      rd_reg(serial_port_pkg::ADDR_ERRORS, v);
      chk("parity flag", 32'h0000_0001, v);
   endtask
   // an unanswered receive request wipes data and flags
   task automatic rx_timeout;
      int w;
      w = 0;
      wr_reg(serial_port_pkg::ADDR_CTRL, 32'h0001_0008);
      wr_reg(serial_port_pkg::ADDR_TIMEOUT, 32'h0000_0002);
      wr_reg(serial_port_pkg::ADDR_IRQ_MASK, 32'h0000_0004);
      wr_reg(serial_port_pkg::ADDR_RXREQ, 32'h0000_0001);
      for (int i = 0; i < 100 && irq !== 1'b1; i++) begin
         @(posedge clock);
         #1 w += wdt_clear;
      end
      chk("timeout irq", 1, irq);
      if (irq !== 1'b1)
         wrap_up;
      chk("watchdog pulses", 1, w != 0);
      rd_reg(serial_port_pkg::ADDR_RXDATA, v);
      chk("timeout data", 0, v);
      rd_reg(serial_port_pkg::ADDR_ERRORS, v);
      chk("timeout flags", 0, v);
   endtask
   // a nine-bit word sampled at the start of each bit
   task automatic rx_wide;
      wr_reg(serial_port_pkg::ADDR_CTRL, 32'h0000_5008);
      line_u.send(9'h1A5, 9, 1'b0, 1'b0, 4);
      rd_reg(serial_port_pkg::ADDR_RXDATA, v);
      chk("wide rx data", 32'h0000_01A5, v);
   endtask
   // a second master holds the readback low
   task automatic collision;
      wr_reg(serial_port_pkg::ADDR_CTRL, 32'h0000_0C08);
      jam <= 1'b1;
      wr_reg(serial_port_pkg::ADDR_TXDATA, 32'h0000_00FF);
      wait_idle;
      rd_reg(serial_port_pkg::ADDR_ERRORS, v);
      chk("line flag", 32'h0000_0040, v);
      wr_reg(serial_port_pkg::ADDR_TXDATA, 32'h0000_0055);
      rd_reg(serial_port_pkg::ADDR_STATUS, v);
      chk("tx refused", 0, v[0]);
      jam <= 1'b0;
   endtask
   // reset, then every scenario in turn
   initial begin
      nrst = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      jam = 1'b0;
      addr = 8'h00;
      wdata = 32'h0000_0000;
      repeat (3) @(posedge clock);
      nrst <= 1'b1;
      rd_reg(serial_port_pkg::ADDR_CTRL, v);
      chk("ctrl reset", 32'h0000_0008, v);
      rd_reg(serial_port_pkg::ADDR_DIV, v);
      chk("div reset", 32'h0000_0364, v);
      rd_reg(8'hFC, v);
      chk("unmapped", 0, v);
      wr_reg(serial_port_pkg::ADDR_DIV, 32'h0000_0004);
      tx_frame(2'b01, 1'b1, 8'hA5);
      tx_frame(2'b10, 1'b0, 8'h3A);
      tx_frame(2'b00, 1'b0, 8'h81);
      rx_parity;
      rx_timeout;
      rx_wide;
      collision;
      wrap_up;
   end
endmodule // configurable_serial_port_tb
